// ---- inc/fifo_regs_pkg.sv ----
package fifo_regs_pkg;

	// Register offsets on the byte-wide register port
	localparam logic [7:0] OFS_WRITE_PTR = 8'h95;
	localparam logic [7:0] OFS_WRITE_PTR_SPARE = 8'h96;
	localparam logic [7:0] OFS_READ_PTR = 8'h97;
	localparam logic [7:0] OFS_READ_PTR_SPARE = 8'h98;
	localparam logic [7:0] OFS_DATA_PORT = 8'h99;
	localparam logic [7:0] OFS_OFFSET_CNT = 8'h9A;
	localparam logic [7:0] OFS_INQ_PORT = 8'h9B;
	localparam logic [7:0] OFS_INQ_COUNT = 8'h9C;
	localparam logic [7:0] OFS_OUTQ_PORT = 8'h9D;
	localparam logic [7:0] OFS_OUTQ_COUNT = 8'h9E;

	// Command block array window
	localparam logic [7:0] ARRAY_FIRST = 8'hA0;
	localparam logic [7:0] ARRAY_LAST = 8'hBF;
	localparam int ARRAY_AW = 5;

	// Data FIFO geometry
	localparam int BYTE_W = 8;
	localparam int WORD_W = 32;
	localparam int PTR_W = 7;
	localparam int LOC_W = 6;
	localparam int LANE_W = 2;
	localparam int LOCATIONS = 64;
	localparam logic [LANE_W-1:0] LANE_HIGH = 2'h3;
	localparam logic [PTR_W-1:0] FIFO_FULL_LEVEL = 7'h40;
	localparam logic [PTR_W-1:0] NEAR_FULL_LEVEL = 7'h3E;

	// Field positions
	localparam int PTR_WRAP_BIT = 6;
	localparam int PTR_FLAG_BIT = 7;
	localparam int AUTO_OFFSET_BIT = 7;

	// Reset values
	localparam logic [PTR_W-1:0] PTR_RESET = 7'h00;
	localparam logic [ARRAY_AW-1:0] OFFSET_RESET = 5'h00;

	// Queues and stream buffer
	localparam int QUEUE_W = 2;
	localparam int QUEUE_DEPTH = 4;
	localparam int QCNT_W = 3;
	localparam int STREAM_DEPTH = 8;

	typedef enum logic {
		RD_IDLE,
		RD_ARRAY
	} rd_state_e;

endpackage

// ---- hw/ready_valid_fifo.sv ----
`timescale 1ns/100ps
module ready_valid_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// Fill level
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH+1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] head;
		logic [AW-1:0] tail;
		logic [CW-1:0] cnt;
	} fifo_state_s;

	fifo_state_s st_r, st_nxt;
	logic push, pop;

	// Index step with wrap for depths that are not powers of two
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH-1)) ? '0 : AW'(p + 1'b1);
	endfunction

	// Push and pop both act in one cycle; a full FIFO refuses the push
	always_comb begin
		st_nxt = st_r;
		push = in_valid && (st_r.cnt != CW'(DEPTH));
		pop = out_ready && (st_r.cnt != '0);
		if (push) begin
			st_nxt.mem[st_r.tail] = in_data;
			st_nxt.tail = bump(st_r.tail);
		end
		if (pop) begin
			st_nxt.head = bump(st_r.head);
		end
		case ({push, pop})
			2'b10: st_nxt.cnt = CW'(st_r.cnt + 1'b1);
			2'b01: st_nxt.cnt = CW'(st_r.cnt - 1'b1);
			default: st_nxt.cnt = st_r.cnt;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Flags read straight from the count
	assign in_ready = (st_r.cnt != CW'(DEPTH));
	assign out_valid = (st_r.cnt != '0);
	assign out_data = st_r.mem[st_r.head];
	assign level = st_r.cnt;

	// Push and pop in one cycle must leave the count alone; both act only when neither full nor empty
	chk_level_balance: assert property (@(posedge clk) disable iff (sys_rst)
		push && pop |=> st_r.cnt == $past(st_r.cnt))
		else $error("push with pop changed the fill count");

endmodule // ready_valid_fifo

// ---- hw/lane_word_ram.sv ----
`timescale 1ns/100ps
module lane_word_ram (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Byte write port
	input wire logic wr_en,
	input wire logic [fifo_regs_pkg::LOC_W-1:0] wr_word,
	input wire logic [fifo_regs_pkg::LANE_W-1:0] wr_lane,
	input wire logic [fifo_regs_pkg::BYTE_W-1:0] wr_byte,
	// Word read port
	input wire logic [fifo_regs_pkg::LOC_W-1:0] rd_word,
	output logic [fifo_regs_pkg::WORD_W-1:0] rd_data
);
	import fifo_regs_pkg::*;

	typedef struct packed {
		logic [LOCATIONS-1:0][WORD_W/BYTE_W-1:0][BYTE_W-1:0] mem;
	} ram_state_s;

	ram_state_s st_r, st_nxt;

	// One byte lane of one word location per write
	always_comb begin
		st_nxt = st_r;
		if (wr_en) begin
			st_nxt.mem[wr_word][wr_lane] = wr_byte;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_data = st_r.mem[rd_word];

endmodule // lane_word_ram

// ---- hw/data_fifo_ports.sv ----
// Operation
// - Write and read pointers, low six bits select one 32-bit FIFO word.
// - Writing a pointer register moves that pointer for later data accesses.
// - Pointer write during host DMA raises break-address and illegal-address flags.
// - Write pointer steps once the high byte of a word is written.
// - Read pointer steps once the high byte of a word is read.
// - Host address bits 1-0 pick which of the four byte lanes comes first.
// - Pointer bit 6 toggles on rollover and separates full from empty.
// - Write pointer bit 7 reads the RAM stress test result, reset zero.
// - Read pointer bit 7 reads set from two words short of full up to full.
// - Data port writes byte to write pointer, reads byte from read pointer.
// - With auto-offset on, array accesses use the five-bit counter as offset.
// - Auto-offset on steps counter per access; off, address decodes directly.
// - Inbound queue write pushes a two-bit pointer; read pops the oldest.
// - Inbound writes ignored with four entries, reads ignored with none.
// - Inbound count shows 0 to 4 in bits 2-0, upper bits zero.
// - Outbound queue pushes sequencer pointers; full writes and empty reads ignored.
// - Driver may pop the outbound queue while the sequencer runs.
// - Outbound count shows 0 to 4 in bits 2-0, readable anytime.
// - FIFO reset clears both pointers, loads byte offsets, reports empty.
`timescale 1ns/100ps
module data_fifo_ports (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [fifo_regs_pkg::BYTE_W-1:0] reg_wdata,
	output logic [fifo_regs_pkg::BYTE_W-1:0] reg_rdata,
	output logic reg_rvalid,
	// Neighbouring control and status
	input wire logic host_dma_enable,
	input wire logic fifo_reset_control,
	input wire logic [fifo_regs_pkg::LANE_W-1:0] host_addr_low,
	input wire logic ram_stress_result,
	// Error flag set pulses
	output logic break_address_interrupt,
	output logic illegal_address_error,
	// Data FIFO status
	output logic fifo_full,
	output logic fifo_empty,
	// Command block array
	output logic [fifo_regs_pkg::ARRAY_AW-1:0] arr_addr,
	output logic arr_wr,
	output logic arr_rd,
	output logic [fifo_regs_pkg::BYTE_W-1:0] arr_wdata,
	input wire logic [fifo_regs_pkg::BYTE_W-1:0] arr_rdata,
	// Host DMA word stream
	output logic dma_valid,
	input wire logic dma_ready,
	output logic [fifo_regs_pkg::WORD_W-1:0] dma_data
);
	import fifo_regs_pkg::*;

	typedef struct packed {
		logic [PTR_W-1:0] wptr;
		logic [PTR_W-1:0] rptr;
		logic [LANE_W-1:0] wlane;
		logic [LANE_W-1:0] rlane;
		logic auto_on;
		logic [ARRAY_AW-1:0] offset_cnt;
		rd_state_e rd_state;
		logic [BYTE_W-1:0] rdata;
		logic rvalid;
		logic brk;
		logic ill;
		logic full;
		logic empty;
		logic near_full;
		logic [ARRAY_AW-1:0] arr_addr;
		logic arr_wr;
		logic arr_rd;
		logic [BYTE_W-1:0] arr_wdata;
	} port_state_s;

	port_state_s st_r, st_nxt;

	logic ram_we;
	logic [WORD_W-1:0] ram_word;
	logic stream_push, stream_ready;
	logic inq_push, inq_pop, inq_valid;
	logic outq_push, outq_pop, outq_valid;
	logic [QUEUE_W-1:0] inq_head, outq_head;
	logic [QCNT_W-1:0] inq_level, outq_level;
	logic [PTR_W-1:0] fill;

	// Pointer step; bit 6 flips as the low six bits roll over
	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		ptr_inc = PTR_W'(p + 1'b1);
	endfunction

	function automatic logic in_array(input logic [7:0] a);
		in_array = (a >= ARRAY_FIRST) && (a <= ARRAY_LAST);
	endfunction

	function automatic logic [PTR_W-1:0] fill_of(input logic [PTR_W-1:0] w, input logic [PTR_W-1:0] r);
		fill_of = PTR_W'(w - r);
	endfunction

	// Next state of every register; register port has one access per cycle
	always_comb begin
		st_nxt = st_r;
		st_nxt.rvalid = 1'b0;
		st_nxt.brk = 1'b0;
		st_nxt.ill = 1'b0;
		st_nxt.arr_wr = 1'b0;
		st_nxt.arr_rd = 1'b0;
		ram_we = 1'b0;
		stream_push = 1'b0;
		inq_push = 1'b0;
		inq_pop = 1'b0;
		outq_push = 1'b0;
		outq_pop = 1'b0;

		// Array read data returns one cycle after the array strobe
		case (st_r.rd_state)
			RD_ARRAY: begin
				st_nxt.rdata = arr_rdata;
				st_nxt.rvalid = 1'b1;
				st_nxt.rd_state = RD_IDLE;
			end
			default: st_nxt.rd_state = RD_IDLE;
		endcase

		if (reg_wr) begin
			case (reg_addr)
				OFS_WRITE_PTR: begin
					if (host_dma_enable) begin
						st_nxt.brk = 1'b1;
						st_nxt.ill = 1'b1;
					end else begin
						st_nxt.wptr = reg_wdata[PTR_W-1:0];
					end
				end
				OFS_READ_PTR: begin
					if (host_dma_enable) begin
						st_nxt.brk = 1'b1;
						st_nxt.ill = 1'b1;
					end else begin
						st_nxt.rptr = reg_wdata[PTR_W-1:0];
					end
				end
				OFS_DATA_PORT: begin
					ram_we = 1'b1;
					st_nxt.wlane = LANE_W'(st_r.wlane + 1'b1);
					if (st_r.wlane == LANE_HIGH) begin
						st_nxt.wptr = ptr_inc(st_r.wptr);
					end
				end
				OFS_OFFSET_CNT: begin
					st_nxt.auto_on = reg_wdata[AUTO_OFFSET_BIT];
					st_nxt.offset_cnt = reg_wdata[ARRAY_AW-1:0];
				end
				OFS_INQ_PORT: inq_push = 1'b1;
				OFS_OUTQ_PORT: outq_push = 1'b1;
				default: begin
					if (in_array(reg_addr)) begin
						st_nxt.arr_wr = 1'b1;
						st_nxt.arr_wdata = reg_wdata;
						if (st_r.auto_on) begin
							st_nxt.arr_addr = st_r.offset_cnt;
							st_nxt.offset_cnt = ARRAY_AW'(st_r.offset_cnt + 1'b1);
						end else begin
							st_nxt.arr_addr = reg_addr[ARRAY_AW-1:0];
						end
					end
				end
			endcase
		end else if (reg_rd) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = '0;
			case (reg_addr)
				OFS_WRITE_PTR: st_nxt.rdata = {ram_stress_result, st_r.wptr};
				OFS_READ_PTR: st_nxt.rdata = {st_r.near_full, st_r.rptr};
				OFS_DATA_PORT: begin
					st_nxt.rdata = ram_word[st_r.rlane*BYTE_W +: BYTE_W];
					st_nxt.rlane = LANE_W'(st_r.rlane + 1'b1);
					if (st_r.rlane == LANE_HIGH) begin
						st_nxt.rptr = ptr_inc(st_r.rptr);
					end
				end
				OFS_OFFSET_CNT: st_nxt.rdata = {st_r.auto_on, 2'h0, st_r.offset_cnt};
				OFS_INQ_PORT: begin
					// Empty queue reads back zero and is not popped
					st_nxt.rdata = inq_valid ? {6'h00, inq_head} : '0;
					inq_pop = 1'b1;
				end
				OFS_INQ_COUNT: st_nxt.rdata = {5'h00, inq_level};
				OFS_OUTQ_PORT: begin
					st_nxt.rdata = outq_valid ? {6'h00, outq_head} : '0;
					outq_pop = 1'b1;
				end
				OFS_OUTQ_COUNT: st_nxt.rdata = {5'h00, outq_level};
				default: begin
					if (in_array(reg_addr)) begin
						st_nxt.rvalid = 1'b0;
						st_nxt.arr_rd = 1'b1;
						st_nxt.rd_state = RD_ARRAY;
						if (st_r.auto_on) begin
							st_nxt.arr_addr = st_r.offset_cnt;
							st_nxt.offset_cnt = ARRAY_AW'(st_r.offset_cnt + 1'b1);
						end else begin
							st_nxt.arr_addr = reg_addr[ARRAY_AW-1:0];
						end
					end
				end
			endcase
		end

		// Host DMA drains whole words; pointer writes are refused meanwhile, so no clash
		if (host_dma_enable && !st_r.empty && stream_ready && !(reg_rd && reg_addr == OFS_DATA_PORT)) begin
			stream_push = 1'b1;
			st_nxt.rptr = ptr_inc(st_r.rptr);
		end

		// Reset of the data FIFO overrides every pointer move of this cycle
		if (fifo_reset_control) begin
			st_nxt.wptr = PTR_RESET;
			st_nxt.rptr = PTR_RESET;
			st_nxt.wlane = host_addr_low;
			st_nxt.rlane = host_addr_low;
			ram_we = 1'b0;
			stream_push = 1'b0;
		end

		// Flags follow the pointers they will hold next cycle
		fill = fill_of(st_nxt.wptr, st_nxt.rptr);
		st_nxt.full = (st_nxt.wptr[LOC_W-1:0] == st_nxt.rptr[LOC_W-1:0])
			&& (st_nxt.wptr[PTR_WRAP_BIT] != st_nxt.rptr[PTR_WRAP_BIT]);
		st_nxt.empty = (st_nxt.wptr == st_nxt.rptr);
		st_nxt.near_full = (fill >= NEAR_FULL_LEVEL) && (fill <= FIFO_FULL_LEVEL);
	end

	// All control state starts cleared, FIFO empty
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
			st_r.empty <= 1'b1;
			st_r.wptr <= PTR_RESET;
			st_r.rptr <= PTR_RESET;
			st_r.offset_cnt <= OFFSET_RESET;
			st_r.rd_state <= RD_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Word storage addressed by the low six pointer bits
	lane_word_ram u_ram (
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_en(ram_we),
		.wr_word(st_r.wptr[LOC_W-1:0]),
		.wr_lane(st_r.wlane),
		.wr_byte(reg_wdata),
		.rd_word(st_r.rptr[LOC_W-1:0]),
		.rd_data(ram_word)
	);

	// Stream buffer lets the DMA side stall without losing words
	ready_valid_fifo #(.WIDTH(WORD_W), .DEPTH(STREAM_DEPTH)) u_stream (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(stream_push),
		.in_ready(stream_ready),
		.in_data(ram_word),
		.out_valid(dma_valid),
		.out_ready(dma_ready),
		.out_data(dma_data),
		.level()
	);

	// Inbound queue, full pushes and empty pops dropped inside
	ready_valid_fifo #(.WIDTH(QUEUE_W), .DEPTH(QUEUE_DEPTH)) u_inq (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(inq_push),
		.in_ready(),
		.in_data(reg_wdata[QUEUE_W-1:0]),
		.out_valid(inq_valid),
		.out_ready(inq_pop),
		.out_data(inq_head),
		.level(inq_level)
	);

	// Outbound queue, same refusal behaviour
	ready_valid_fifo #(.WIDTH(QUEUE_W), .DEPTH(QUEUE_DEPTH)) u_outq (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(outq_push),
		.in_ready(),
		.in_data(reg_wdata[QUEUE_W-1:0]),
		.out_valid(outq_valid),
		.out_ready(outq_pop),
		.out_data(outq_head),
		.level(outq_level)
	);

	assign reg_rdata = st_r.rdata;
	assign reg_rvalid = st_r.rvalid;
	assign break_address_interrupt = st_r.brk;
	assign illegal_address_error = st_r.ill;
	assign fifo_full = st_r.full;
	assign fifo_empty = st_r.empty;
	assign arr_addr = st_r.arr_addr;
	assign arr_wr = st_r.arr_wr;
	assign arr_rd = st_r.arr_rd;
	assign arr_wdata = st_r.arr_wdata;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_ptr_write_refused: assert property (
		reg_wr && reg_addr == OFS_WRITE_PTR && host_dma_enable |=> break_address_interrupt && illegal_address_error)
		else $error("pointer write under DMA did not raise both flags");

	chk_wptr_reposition: assert property (
		reg_wr && reg_addr == OFS_WRITE_PTR && !host_dma_enable && !fifo_reset_control
		|=> st_r.wptr == $past(reg_wdata[PTR_W-1:0]))
		else $error("write pointer not moved by register write");

	chk_wptr_high_step: assert property (
		reg_wr && reg_addr == OFS_DATA_PORT && st_r.wlane == LANE_HIGH && !fifo_reset_control
		|=> st_r.wptr == ptr_inc($past(st_r.wptr)) && st_r.wlane == '0)
		else $error("write pointer did not step after high byte");

	chk_rptr_high_step: assert property (
		reg_rd && !reg_wr && reg_addr == OFS_DATA_PORT && st_r.rlane == LANE_HIGH && !fifo_reset_control
		&& !host_dma_enable |=> st_r.rptr == ptr_inc($past(st_r.rptr)) && st_r.rlane == '0 && reg_rvalid)
		else $error("read pointer did not step after high byte");

	chk_reset_empty: assert property (
		fifo_reset_control |=> fifo_empty && !fifo_full && st_r.wlane == $past(host_addr_low)
		&& st_r.rptr == PTR_RESET)
		else $error("FIFO reset did not leave an empty FIFO");

	chk_full_wrap: assert property (
		fifo_full == ((st_r.wptr[LOC_W-1:0] == st_r.rptr[LOC_W-1:0])
		&& (st_r.wptr[PTR_WRAP_BIT] != st_r.rptr[PTR_WRAP_BIT])))
		else $error("full flag disagrees with pointers");

	chk_inq_full_drop: assert property (
		reg_wr && reg_addr == OFS_INQ_PORT && inq_level == 3'h4 |=> inq_level == 3'h4)
		else $error("push into full inbound queue was taken");

	chk_auto_offset: assert property (
		reg_wr && in_array(reg_addr) && st_r.auto_on
		|=> arr_wr && arr_addr == $past(st_r.offset_cnt)
		&& st_r.offset_cnt == ARRAY_AW'($past(st_r.offset_cnt) + 1'b1))
		else $error("auto offset access used wrong offset or did not step");

	chk_queue_balance: assert property (
		inq_push && inq_pop && inq_level != 3'h0 && inq_level != 3'h4 |=> $stable(inq_level))
		else $error("push with pop changed inbound count");

endmodule // data_fifo_ports

// ---- verif/array_far_end.sv ----
`timescale 1ns/100ps
module array_far_end (
	// Clock
	input wire logic clk,
	// Command block array side
	input wire logic [fifo_regs_pkg::ARRAY_AW-1:0] arr_addr,
	input wire logic arr_wr,
	input wire logic arr_rd,
	input wire logic [fifo_regs_pkg::BYTE_W-1:0] arr_wdata,
	output logic [fifo_regs_pkg::BYTE_W-1:0] arr_rdata,
	// Word stream sink
	input wire logic stall,
	output logic dma_ready
);
	import fifo_regs_pkg::*;
	logic [BYTE_W-1:0] mem [32];
	logic [BYTE_W-1:0] junk_r = 8'h5A;
	// Array storage, no reset like the real RAM
	always @(posedge clk) begin
		junk_r <= ~junk_r;
		if (arr_wr) begin
			mem[arr_addr] <= arr_wdata;
		end
	end
	// Unselected reads show a toggling pattern so stale data cannot pass
	assign arr_rdata = arr_rd ? mem[arr_addr] : junk_r;
	// Sink takes words unless the bench stalls it
	assign dma_ready = !stall;
endmodule // array_far_end

// ---- verif/data_fifo_ports_and_command_queues_tb_top.sv ----
`timescale 1ns/100ps
module data_fifo_ports_and_command_queues_tb_top;
	import fifo_regs_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic host_dma_enable = 1'b0;
	logic fifo_reset_control = 1'b0;
	logic [1:0] host_addr_low = 2'h0;
	logic ram_stress_result = 1'b0;
	logic brk;
	logic ill;
	logic fifo_full;
	logic fifo_empty;
	logic [4:0] arr_addr;
	logic arr_wr;
	logic arr_rd;
	logic [7:0] arr_wdata;
	logic [7:0] arr_rdata;
	logic dma_valid;
	logic dma_ready;
	logic stall = 1'b0;
	logic [31:0] dma_data;
	int failures = 0;
	int tests_run = 0;

	// Free-running 250 MHz clock
	always #2 clk = ~clk;

	data_fifo_ports dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .host_dma_enable(host_dma_enable),
		.fifo_reset_control(fifo_reset_control), .host_addr_low(host_addr_low),
		.ram_stress_result(ram_stress_result), .break_address_interrupt(brk), .illegal_address_error(ill),
		.fifo_full(fifo_full), .fifo_empty(fifo_empty), .arr_addr(arr_addr), .arr_wr(arr_wr), .arr_rd(arr_rd),
		.arr_wdata(arr_wdata), .arr_rdata(arr_rdata), .dma_valid(dma_valid), .dma_ready(dma_ready),
		.dma_data(dma_data));

	array_far_end far (.clk(clk), .arr_addr(arr_addr), .arr_wr(arr_wr), .arr_rd(arr_rd), .arr_wdata(arr_wdata),
		.arr_rdata(arr_rdata), .stall(stall), .dma_ready(dma_ready));

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Every bus task starts and ends 1 ns after a rising edge
	// Idle edge first, so a strobe never drops and rises in one time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk) #1;
		reg_wr = 1'b0;
	endtask

	task automatic rc(input string what, input logic [7:0] a, input logic [7:0] exp);
		int i;
		@(posedge clk) #1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk) #1;
		reg_rd = 1'b0;
		for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) begin
			@(posedge clk) #1;
		end
		chk(what, reg_rvalid === 1'b1 ? {24'h0, reg_rdata} : 32'hDEAD, {24'h0, exp});
	endtask

	// Host address is loaded before the reset pulse
	task automatic freset(input logic [1:0] lane);
		host_addr_low = lane;
		fifo_reset_control = 1'b1;
		@(posedge clk) #1;
		fifo_reset_control = 1'b0;
	endtask

	task automatic t_reset();
		chk("empty flag", fifo_empty, 1'b1);
		rc("wptr", OFS_WRITE_PTR, 8'h00);
		rc("rptr", OFS_READ_PTR, 8'h00);
		rc("spare w", OFS_WRITE_PTR_SPARE, 8'h00);
		rc("spare r", OFS_READ_PTR_SPARE, 8'h00);
		rc("offset", OFS_OFFSET_CNT, 8'h00);
		rc("in count", OFS_INQ_COUNT, 8'h00);
		rc("out count", OFS_OUTQ_COUNT, 8'h00);
		rc("unmapped", 8'h80, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_data();
		int k;
		freset(2'h0);
		for (k = 0; k < 8; k++) wr(OFS_DATA_PORT, 8'h10 + k[7:0]);
		chk("not empty", fifo_empty, 1'b0);
		rc("wptr two words", OFS_WRITE_PTR, 8'h02);
		ram_stress_result = 1'b1;
		rc("stress flag", OFS_WRITE_PTR, 8'h82);
		ram_stress_result = 1'b0;
		for (k = 0; k < 8; k++) rc("data byte", OFS_DATA_PORT, 8'h10 + k[7:0]);
		rc("rptr two words", OFS_READ_PTR, 8'h02);
		chk("empty again", fifo_empty, 1'b1);
		// High lane first: one byte completes the word
		freset(2'h3);
		rc("rptr cleared", OFS_READ_PTR, 8'h00);
		wr(OFS_DATA_PORT, 8'hC3);
		rc("wptr high lane", OFS_WRITE_PTR, 8'h01);
		rc("byte high lane", OFS_DATA_PORT, 8'hC3);
		rc("rptr high lane", OFS_READ_PTR, 8'h01);
		$display("test data port done");
	endtask

	task automatic t_wrap();
		int k;
		freset(2'h0);
		wr(OFS_WRITE_PTR, 8'h3F);
		wr(OFS_READ_PTR, 8'h3F);
		chk("empty at 3F", fifo_empty, 1'b1);
		for (k = 0; k < 4; k++) wr(OFS_DATA_PORT, k[7:0]);
		rc("wptr wrap bit", OFS_WRITE_PTR, 8'h40);
		wr(OFS_READ_PTR, 8'h00);
		chk("full", fifo_full, 1'b1);
		rc("near full at full", OFS_READ_PTR, 8'h80);
		wr(OFS_READ_PTR, 8'h02);
		rc("near full two short", OFS_READ_PTR, 8'h82);
		wr(OFS_READ_PTR, 8'h03);
		rc("three short", OFS_READ_PTR, 8'h03);
		wr(OFS_READ_PTR, 8'h3F);
		rc("moved pointer data", OFS_DATA_PORT, 8'h00);
		wr(OFS_READ_PTR, 8'h40);
		chk("empty after wrap", fifo_empty, 1'b1);
		chk("not full", fifo_full, 1'b0);
		$display("test wrap done");
	endtask

	task automatic t_dma();
		int k;
		int i;
		logic [7:0] b;
		freset(2'h0);
		host_dma_enable = 1'b1;
		wr(OFS_WRITE_PTR, 8'h11);
		chk("break pulse", brk, 1'b1);
		chk("illegal pulse", ill, 1'b1);
		@(posedge clk) #1;
		chk("break pulse ends", brk, 1'b0);
		host_dma_enable = 1'b0;
		rc("wptr kept", OFS_WRITE_PTR, 8'h00);
		// Ten words against a stalled sink: the buffer must refuse the last two
		stall = 1'b1;
		for (k = 0; k < 40; k++) wr(OFS_DATA_PORT, k[7:0]);
		host_dma_enable = 1'b1;
		repeat (20) @(posedge clk);
		#1;
		rc("rptr at buffer depth", OFS_READ_PTR, 8'(STREAM_DEPTH));
		stall = 1'b0;
		for (k = 0; k < 10; k++) begin
			for (i = 0; i < 20 && dma_valid !== 1'b1; i++) @(posedge clk) #1;
			b = 8'(k * 4);
			chk("stream word", dma_data, {b + 8'h3, b + 8'h2, b + 8'h1, b});
			@(posedge clk) #1;
		end
		host_dma_enable = 1'b0;
		chk("drained", fifo_empty, 1'b1);
		$display("test stream done");
	endtask

	task automatic t_queues();
		int q;
		int k;
		logic [7:0] port;
		logic [7:0] cnt;
		for (q = 0; q < 2; q++) begin
			port = q ? OFS_OUTQ_PORT : OFS_INQ_PORT;
			cnt = q ? OFS_OUTQ_COUNT : OFS_INQ_COUNT;
			for (k = 0; k < 5; k++) wr(port, 8'hFC | (8'h3 - k[7:0]));
			rc("queue count full", cnt, 8'h04);
			wr(cnt, 8'h07);
			for (k = 0; k < 4; k++) rc("queue head", port, 8'h03 - k[7:0]);
			rc("empty pop", port, 8'h00);
			rc("count drained", cnt, 8'h00);
		end
		$display("test queues done");
	endtask

	task automatic t_array();
		wr(8'hA3, 8'h5C);
		@(posedge clk) #1;
		chk("direct slot", far.mem[3], 8'h5C);
		rc("direct read", 8'hA3, 8'h5C);
		wr(OFS_OFFSET_CNT, 8'h9E);
		wr(8'hA0, 8'h61);
		wr(8'hA0, 8'h62);
		@(posedge clk) #1;
		chk("auto slot 30", far.mem[30], 8'h61);
		chk("auto slot 31", far.mem[31], 8'h62);
		rc("counter wrapped", OFS_OFFSET_CNT, 8'h80);
		wr(OFS_OFFSET_CNT, 8'h9F);
		rc("auto read", 8'hA5, 8'h62);
		rc("counter stepped", OFS_OFFSET_CNT, 8'h80);
		wr(OFS_OFFSET_CNT, 8'h00);
		$display("test array done");
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Main sequence after ten reset cycles
	initial begin
		repeat (10) @(posedge clk);
		#1 sys_rst = 1'b0;
		t_reset();
		t_data();
		t_wrap();
		t_dma();
		t_queues();
		t_array();
		wrap_up();
	end

	// Watchdog, well beyond the few hundred cycles the tests need
	initial begin
		#40000;
		failures++;
		$display("watchdog expired");
		wrap_up();
	end
endmodule // data_fifo_ports_and_command_queues_tb_top
